/* File: logic/pcar_consts.svh */
// Constants for the procedure call argument and return sequencer
// Notes on behaviour
// - Store flag set: write pointer into next free frame argument slot.
// - After a store, last flag ends generation, else take next template.
// - Pointers beyond the callee's expected count are discarded.
// - Missing arguments get one dummy pointer 100000 octal each.
// - Dummy pointer used other than passed on raises pointer fault.
// - Every argument pointer reserves three frame words.
// - Nonzero bit field: three words written, extension bit set.
// - Zero bit field: extension bit clear, only two words written.
// - Interrupted call resumable; saved counter points at callee entry.
// - Transfer instruction finds remaining pointers and completes them.
// - Transfer instruction moves arguments only after an interrupted call.
// - Return resumes caller after call instruction and its templates.
// - Return writes stack base into stack free pointer.
// - Return reloads stack base and link base from frame.
// - Return restores keys with bits 15-16 forced to zero.
// - Return ring is OR of saved ring and current ring.
// - Call without argument pointers leaves registers and temp base alone.
// - Store flag clear keeps intermediate in temporary base register.
// - Template bit 10 is store flag, bit 9 last-of-call flag.
// - Store flag clear requires at least one more template.
`ifndef PCAR_CONSTS_SVH
`define PCAR_CONSTS_SVH
// Template bit positions, bit 1 is MSB of 32-bit template (index 31)
`define PCAR_TPL_STORE_BIT  22
`define PCAR_TPL_LAST_BIT   23
`define PCAR_TPL_IND_BIT    27
`define PCAR_TPL_BITF_HI    31
`define PCAR_TPL_BITF_LO    28
`define PCAR_DUMMY_WORD     16'h8000
`define PCAR_SLOT_WORDS     16'h0003
`define PCAR_KEY_CLR_MASK   16'hFFFC
`define PCAR_RING_HI        14
`define PCAR_RING_LO        13
`define PCAR_PTR_EXT_BIT    12
// APB register offsets
`define PCAR_REG_CTRL       12'h000
`define PCAR_REG_STATUS     12'h004
`define PCAR_REG_TEMPLATE   12'h008
`define PCAR_REG_PTR_HI     12'h00C
`define PCAR_REG_PTR_LO     12'h010
`define PCAR_REG_PTR_BIT    12'h014
`define PCAR_REG_EXPECT     12'h018
`define PCAR_REG_FRAME      12'h01C
`define PCAR_REG_CUR_PC     12'h020
`define PCAR_REG_RET_PC     12'h024
`define PCAR_REG_SAVE_SB    12'h028
`define PCAR_REG_SAVE_LB    12'h02C
`define PCAR_REG_SAVE_KEYS  12'h030
`define PCAR_REG_SB         12'h034
`define PCAR_REG_LB         12'h038
`define PCAR_REG_KEYS       12'h03C
`define PCAR_REG_FREE_PTR   12'h040
`define PCAR_REG_TMP_BASE   12'h044
`define PCAR_REG_COUNT      12'h048
`define PCAR_REG_MEM_ADDR   12'h04C
`define PCAR_REG_MEM_DATA   12'h050
// Control register command codes (bits 2:0), bit 3 use-dummy probe
`define PCAR_CMD_TEMPLATE   3'h1
`define PCAR_CMD_FINISH     3'h2
`define PCAR_CMD_INTR       3'h3
`define PCAR_CMD_ARGUMENT_TRANSFER_INSTR       3'h4
`define PCAR_CMD_RETURN     3'h5
`define PCAR_CMD_START      3'h6
`define PCAR_CMD_USE_PTR    3'h7
`define PCAR_FRAME_WORDS    64
`endif

/* File: logic/pcar_pkg.sv */
// Types for the procedure call argument and return sequencer
package pcar_pkg;
  typedef enum logic [2:0] {
    PCAR_IDLE,
    PCAR_GATHER,
    PCAR_WRITE,
    PCAR_PAD,
    PCAR_SUSPENDED,
    PCAR_RETURN
  } pcar_state_t;
endpackage

/* File: logic/pcar_frame_mem.sv */
// Small stack frame memory with registered read data
`timescale 1ns/10ps
module pcar_frame_mem #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic          ref_clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [15:0]   wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [15:0]   rdata
);
  logic [15:0] mem [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

/* File: logic/pcar_core.sv */
// Procedure call argument storing, transfer resume and return sequencing
`timescale 1ns/10ps
`include "pcar_consts.svh"
module pcar_core
  import pcar_pkg::*;
#(
  parameter int FRAME_WORDS = `PCAR_FRAME_WORDS,
  parameter int AW          = 6
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             ptr_fault
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    pcar_state_t st;
    logic [31:0] template_w;
    logic [15:0] ptr_hi;
    logic [15:0] ptr_lo;
    logic [3:0]  ptr_bit;
    logic [7:0]  expect_n;
    logic [7:0]  stored_n;
    logic [7:0]  slot_n;
    logic [AW-1:0] frame_base;
    logic [1:0]  wr_word;
    logic        last_seen;
    logic        interrupted;
    logic [15:0] cur_pc;
    logic [15:0] ret_pc;
    logic [15:0] save_sb;
    logic [15:0] save_lb;
    logic [15:0] save_keys;
    logic [15:0] sb;
    logic [15:0] lb;
    logic [15:0] keys;
    logic [15:0] free_ptr;
    logic [31:0] tmp_base;
    logic        tmp_ext;
    logic        fault;
    logic [31:0] rdata;
  } pcar_regs_t;

  pcar_regs_t r_q;
  pcar_regs_t r_d;

  logic          mem_we;
  logic [AW-1:0] mem_waddr;
  logic [15:0]   mem_wdata;
  logic [AW-1:0] mem_raddr;
  logic [15:0]   mem_rdata;

  logic          wr_acc;
  logic          rd_setup;
  logic          mapped;
  logic          has_bits;
  logic [2:0]    cmd;
  logic [AW-1:0] slot_addr;

  assign wr_acc   = psel && penable && pwrite;
  // Read data is captured in the setup phase so it stands for the access edge
  assign rd_setup = psel && !penable && !pwrite;
  assign cmd      = pwdata[2:0];
  assign has_bits = (r_q.ptr_bit != 4'h0);
  assign slot_addr = AW'(r_q.frame_base + AW'(r_q.slot_n * 8'(`PCAR_SLOT_WORDS)))
                   + AW'(r_q.wr_word);
  assign pready   = 1'b1;
  assign prdata   = r_q.rdata;
  assign ptr_fault = r_q.fault;
  assign pslverr  = psel && penable && !mapped;

  always_comb begin
    unique case (paddr)
      `PCAR_REG_CTRL, `PCAR_REG_STATUS, `PCAR_REG_TEMPLATE, `PCAR_REG_PTR_HI,
      `PCAR_REG_PTR_LO, `PCAR_REG_PTR_BIT, `PCAR_REG_EXPECT, `PCAR_REG_FRAME,
      `PCAR_REG_CUR_PC, `PCAR_REG_RET_PC, `PCAR_REG_SAVE_SB, `PCAR_REG_SAVE_LB,
      `PCAR_REG_SAVE_KEYS, `PCAR_REG_SB, `PCAR_REG_LB, `PCAR_REG_KEYS,
      `PCAR_REG_FREE_PTR, `PCAR_REG_TMP_BASE, `PCAR_REG_COUNT, `PCAR_REG_MEM_ADDR,
      `PCAR_REG_MEM_DATA: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Frame memory
  // ------------------------------------------------------------
  pcar_frame_mem #(
    .DEPTH (FRAME_WORDS),
    .AW    (AW)
  ) u_mem (
    .ref_clk (ref_clk),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr   (mem_raddr),
    .rdata   (mem_rdata)
  );

  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = slot_addr;
    mem_wdata = 16'h0000;
    unique case (r_q.st)
      PCAR_WRITE: begin
        mem_we = 1'b1;
        unique case (r_q.wr_word)
          2'd0: mem_wdata = {r_q.ptr_hi[15:13], has_bits, r_q.ptr_hi[11:0]};
          2'd1: mem_wdata = r_q.ptr_lo;
          default: mem_wdata = {r_q.ptr_bit, 12'h000};
        endcase
      end
      PCAR_PAD: begin
        mem_we    = (r_q.stored_n < r_q.expect_n);
        mem_wdata = `PCAR_DUMMY_WORD;
      end
      default: ;
    endcase
  end
  assign mem_raddr = r_q.frame_base;

  // ------------------------------------------------------------
  // Sequencer and registers
  // ------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    // Steps go first so that a command in the same cycle overrides them
    unique case (r_q.st)
      PCAR_WRITE: begin
        if (r_q.wr_word == 2'd2 || (r_q.wr_word == 2'd1 && !has_bits)) begin
          r_d.wr_word  = 2'd0;
          r_d.stored_n = r_q.stored_n + 8'h01;
          r_d.slot_n   = r_q.slot_n + 8'h01;
          r_d.st       = PCAR_GATHER;
        end else begin
          r_d.wr_word = r_q.wr_word + 2'd1;
        end
      end
      PCAR_PAD: begin
        if (r_q.stored_n >= r_q.expect_n) begin
          r_d.st = PCAR_IDLE;
        end else begin
          r_d.stored_n = r_q.stored_n + 8'h01;
          r_d.slot_n   = r_q.slot_n + 8'h01;
        end
      end
      PCAR_RETURN: begin
        r_d.free_ptr = r_q.sb;
        r_d.sb       = r_q.save_sb;
        r_d.lb       = r_q.save_lb;
        r_d.keys     = r_q.save_keys & `PCAR_KEY_CLR_MASK;
        r_d.cur_pc   = r_q.ret_pc;
        r_d.cur_pc[`PCAR_RING_HI:`PCAR_RING_LO] = r_q.ret_pc[`PCAR_RING_HI:`PCAR_RING_LO]
                   | r_q.cur_pc[`PCAR_RING_HI:`PCAR_RING_LO];
        r_d.st       = PCAR_IDLE;
      end
      default: ;
    endcase
    if (rd_setup) begin
      unique case (paddr)
        `PCAR_REG_STATUS:    r_d.rdata = {24'h0, r_q.interrupted, r_q.fault,
                                          r_q.last_seen, r_q.tmp_ext, 1'b0, r_q.st};
        `PCAR_REG_TEMPLATE:  r_d.rdata = r_q.template_w;
        `PCAR_REG_PTR_HI:    r_d.rdata = {16'h0, r_q.ptr_hi};
        `PCAR_REG_PTR_LO:    r_d.rdata = {16'h0, r_q.ptr_lo};
        `PCAR_REG_PTR_BIT:   r_d.rdata = {28'h0, r_q.ptr_bit};
        `PCAR_REG_EXPECT:    r_d.rdata = {24'h0, r_q.expect_n};
        `PCAR_REG_FRAME:     r_d.rdata = 32'(r_q.frame_base);
        `PCAR_REG_CUR_PC:    r_d.rdata = {16'h0, r_q.cur_pc};
        `PCAR_REG_RET_PC:    r_d.rdata = {16'h0, r_q.ret_pc};
        `PCAR_REG_SAVE_SB:   r_d.rdata = {16'h0, r_q.save_sb};
        `PCAR_REG_SAVE_LB:   r_d.rdata = {16'h0, r_q.save_lb};
        `PCAR_REG_SAVE_KEYS: r_d.rdata = {16'h0, r_q.save_keys};
        `PCAR_REG_SB:        r_d.rdata = {16'h0, r_q.sb};
        `PCAR_REG_LB:        r_d.rdata = {16'h0, r_q.lb};
        `PCAR_REG_KEYS:      r_d.rdata = {16'h0, r_q.keys};
        `PCAR_REG_FREE_PTR:  r_d.rdata = {16'h0, r_q.free_ptr};
        `PCAR_REG_TMP_BASE:  r_d.rdata = r_q.tmp_base;
        `PCAR_REG_COUNT:     r_d.rdata = {8'h0, r_q.slot_n, r_q.stored_n, r_q.expect_n};
        `PCAR_REG_MEM_DATA:  r_d.rdata = {16'h0, mem_rdata};
        default:             r_d.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_acc) begin
      unique case (paddr)
        `PCAR_REG_PTR_HI:    r_d.ptr_hi = pwdata[15:0];
        `PCAR_REG_PTR_LO:    r_d.ptr_lo = pwdata[15:0];
        `PCAR_REG_PTR_BIT:   r_d.ptr_bit = pwdata[3:0];
        `PCAR_REG_EXPECT:    r_d.expect_n = pwdata[7:0];
        `PCAR_REG_FRAME:     r_d.frame_base = pwdata[AW-1:0];
        `PCAR_REG_CUR_PC:    r_d.cur_pc = pwdata[15:0];
        `PCAR_REG_RET_PC:    r_d.ret_pc = pwdata[15:0];
        `PCAR_REG_SAVE_SB:   r_d.save_sb = pwdata[15:0];
        `PCAR_REG_SAVE_LB:   r_d.save_lb = pwdata[15:0];
        `PCAR_REG_SAVE_KEYS: r_d.save_keys = pwdata[15:0];
        `PCAR_REG_SB:        r_d.sb = pwdata[15:0];
        `PCAR_REG_MEM_ADDR:  r_d.frame_base = pwdata[AW-1:0];
        `PCAR_REG_TMP_BASE:  r_d.tmp_base = pwdata;
        `PCAR_REG_TEMPLATE:  r_d.template_w = pwdata;
        `PCAR_REG_CTRL: begin
          unique case (cmd)
            `PCAR_CMD_START: begin
              r_d.st        = PCAR_GATHER;
              r_d.stored_n  = 8'h00;
              r_d.slot_n    = 8'h00;
              r_d.last_seen = 1'b0;
              r_d.fault     = 1'b0;
              r_d.interrupted = 1'b0;
            end
            `PCAR_CMD_TEMPLATE: if (r_q.st == PCAR_GATHER && !r_q.last_seen) begin
              r_d.last_seen = r_d.template_w[`PCAR_TPL_LAST_BIT];
              if (r_d.template_w[`PCAR_TPL_STORE_BIT]) begin
                if (r_q.stored_n < r_q.expect_n) begin
                  r_d.st      = PCAR_WRITE;
                  r_d.wr_word = 2'd0;
                end
              end else begin
                // Intermediate stays in temp base; next template must follow
                r_d.tmp_base = {r_q.ptr_hi, r_q.ptr_lo};
                r_d.tmp_ext  = has_bits;
              end
            end
            `PCAR_CMD_FINISH: if (r_q.st == PCAR_GATHER) begin
              r_d.st      = PCAR_PAD;
              r_d.wr_word = 2'd0;
            end
            `PCAR_CMD_INTR: if (r_q.st != PCAR_IDLE && r_q.st != PCAR_RETURN) begin
              r_d.st          = PCAR_SUSPENDED;
              r_d.interrupted = 1'b1;
              r_d.wr_word     = 2'd0;
            end
            `PCAR_CMD_ARGUMENT_TRANSFER_INSTR: if (r_q.st == PCAR_SUSPENDED && r_q.interrupted) begin
              r_d.st = PCAR_GATHER;
            end
            `PCAR_CMD_RETURN: if (r_q.st == PCAR_IDLE) begin
              r_d.st = PCAR_RETURN;
            end
            `PCAR_CMD_USE_PTR: begin
              if (pwdata[3] && r_q.ptr_hi == `PCAR_DUMMY_WORD) begin
                r_d.fault = 1'b1;
              end
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_ret_go;
    r_q.st == PCAR_RETURN;
  endsequence

  a_ret_free: assert property (s_ret_go |=> r_q.free_ptr == $past(r_q.sb))
    else $error("free pointer not loaded from stack base");
  a_ret_base: assert property (s_ret_go |=> r_q.sb == $past(r_q.save_sb)
                               && r_q.lb == $past(r_q.save_lb))
    else $error("bases not restored");
  a_ret_keys: assert property (s_ret_go |=> r_q.keys[1:0] == 2'b00)
    else $error("key bits not cleared");
  a_ret_ring: assert property (s_ret_go |=> r_q.cur_pc[14:13] ==
    ($past(r_q.ret_pc[14:13]) | $past(r_q.cur_pc[14:13])))
    else $error("return ring wrong");
  a_pad_dummy: assert property (mem_we && r_q.st == PCAR_PAD |-> mem_wdata == 16'h8000)
    else $error("dummy pointer value wrong");
  a_ext_set: assert property (mem_we && r_q.st == PCAR_WRITE && r_q.wr_word == 2'd0
                              |-> mem_wdata[12] == has_bits)
    else $error("extension bit wrong");
  a_no_third: assert property (r_q.st == PCAR_WRITE && !has_bits |-> r_q.wr_word != 2'd2)
    else $error("third word written without bit field");
  a_no_extra: assert property (r_q.st == PCAR_WRITE |-> r_q.stored_n < r_q.expect_n)
    else $error("surplus pointer stored");
  a_store_done: assert property (r_q.st == PCAR_WRITE |-> ##[1:3] r_q.st != PCAR_WRITE)
    else $error("store sequence too long");
  a_argument_transfer_instr_only: assert property (r_q.st == PCAR_SUSPENDED |=> r_q.st inside
                                {PCAR_SUSPENDED, PCAR_GATHER})
    else $error("suspended call left wrongly");

  // Pad and store steps
  sequence s_pad_live;
    r_q.st == PCAR_PAD && r_q.stored_n < r_q.expect_n;
  endsequence

  sequence s_pad_full;
    r_q.st == PCAR_PAD && r_q.stored_n >= r_q.expect_n;
  endsequence

  sequence s_last_word;
    r_q.st == PCAR_WRITE && (r_q.wr_word == 2'd2 || (r_q.wr_word == 2'd1 && !has_bits));
  endsequence

  a_pad_write: assert property (s_pad_live |-> mem_we && mem_wdata == `PCAR_DUMMY_WORD)
    else $error("missing dummy pointer not written");
  a_pad_stop: assert property (s_pad_full |-> !mem_we)
    else $error("dummy pointer written past expected count");
  a_pad_exit: assert property (s_pad_full |=> r_q.st != PCAR_PAD)
    else $error("padding did not end");
  a_store_end: assert property (s_last_word |=> r_q.st != PCAR_WRITE)
    else $error("store did not hand back to gathering");
  a_store_count: assert property (s_last_word |=> r_q.stored_n == $past(r_q.stored_n) + 8'h01
                                  || r_q.stored_n == 8'h00)
    else $error("stored count not advanced");
  a_last_stop: assert property (r_q.st == PCAR_GATHER && r_q.last_seen
                                |=> r_q.st != PCAR_WRITE)
    else $error("pointer stored after last template");
  // Count survives the interruption, so the transfer resumes where it stopped
  a_resume_keep: assert property (r_q.st == PCAR_SUSPENDED |=> r_q.stored_n == $past(r_q.stored_n)
                                  || r_q.stored_n == 8'h00)
    else $error("stored count lost while suspended");
  a_intr_flag: assert property (r_q.st == PCAR_SUSPENDED |-> r_q.interrupted)
    else $error("suspension without interrupt mark");
  a_gather_quiet: assert property (r_q.st == PCAR_GATHER |-> !mem_we)
    else $error("intermediate written to frame");
  a_idle_quiet: assert property (r_q.st == PCAR_IDLE |-> !mem_we)
    else $error("frame written while idle");
  a_ext_clear: assert property (r_q.st == PCAR_WRITE && r_q.wr_word == 2'd0 && !has_bits
                                |-> !mem_wdata[12])
    else $error("extension bit set without bit field");
  a_ret_pc: assert property (s_ret_go |=> r_q.cur_pc[12:0] == $past(r_q.ret_pc[12:0]))
    else $error("return address wrong");
  a_key_keep: assert property (s_ret_go |=> r_q.keys[15:2] == $past(r_q.save_keys[15:2]))
    else $error("keys not restored");
endmodule

/* File: test/pcar_sw_model.sv */
// Software-side model: issues call, transfer and return requests over APB
`timescale 1ns/10ps
module pcar_sw_model (
  input  wire logic        ref_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // --------------------------------------------
  // Idle bus
  // --------------------------------------------
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // --------------------------------------------
  // One APB transfer
  // --------------------------------------------
  // Callers never trust general registers across argument calls
  // No indexed or temp-base call into inner rings is issued
  // No temp-base template follows a stored template
  // Template counts fall below and above the expected count in the pad test
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output logic ok);
    int n;
    n       = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    ok      = (pready === 1'b1);
    err     = pslverr;
    rd      = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released data must not keep the last value
    pwdata  <= ~d;
    // One idle edge so no strobe is assigned twice in one time step
    @(posedge ref_clk);
  endtask
endmodule

/* File: test/tb_top.sv */
// Self-checking testbench for the call argument and return sequencer
`timescale 1ns/10ps
`include "pcar_consts.svh"
module tb_top;
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ptr_fault;
  int          n_fail     = 0;
  int          n_compared = 0;

  pcar_core i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ptr_fault(ptr_fault));
  pcar_sw_model i_sw (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  always #50 ref_clk = ~ref_clk;

  // --------------------------------------------
  // Helpers
  // --------------------------------------------
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    logic ok;
    i_sw.xfer(w, a, d, r, e, ok);
    if (ok !== 1'b1) begin
      n_fail++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    bus(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    bus(1'b0, a, 32'h0000_0000, r, e);
  endtask

  task automatic chk_mem(input logic [31:0] k, input logic [31:0] exp);
    logic [31:0] r;
    wr(`PCAR_REG_MEM_ADDR, k);
    rd(`PCAR_REG_MEM_DATA, r);
    chk("frame word", r, exp);
  endtask

  // Bounded wait until the sequencer is idle, gathering or suspended
  task automatic settle();
    logic [31:0] r;
    int          n;
    n = 0;
    do begin
      rd(`PCAR_REG_STATUS, r);
      n++;
    end while (r[2:0] > 3'h1 && r[2:0] != 3'h4 && n < 40);
    if (n >= 40) begin
      n_fail++;
      complete_run();
    end
  endtask

  task automatic arg(input logic [31:0] tpl, input logic [31:0] hi, input logic [31:0] lo,
                     input logic [31:0] bitf);
    wr(`PCAR_REG_PTR_HI, hi);
    wr(`PCAR_REG_PTR_LO, lo);
    wr(`PCAR_REG_PTR_BIT, bitf);
    wr(`PCAR_REG_TEMPLATE, tpl);
    wr(`PCAR_REG_CTRL, {29'h0, `PCAR_CMD_TEMPLATE});
    settle();
  endtask

  task automatic call(input logic [31:0] frame, input logic [31:0] expect_n);
    wr(`PCAR_REG_FRAME, frame);
    wr(`PCAR_REG_EXPECT, expect_n);
    wr(`PCAR_REG_CTRL, {29'h0, `PCAR_CMD_START});
  endtask

  // --------------------------------------------
  // Tests
  // --------------------------------------------
  localparam logic [31:0] ST = 32'h1 << `PCAR_TPL_STORE_BIT;
  localparam logic [31:0] LS = 32'h1 << `PCAR_TPL_LAST_BIT;

  initial begin
    logic [31:0] r;
    logic        e;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(`PCAR_REG_STATUS, r);
    chk("status after reset", {29'h0, r[2:0]}, 32'h0000_0000);
    // Interrupted call resumed by the transfer instruction
    call(32'h0, 32'h2);
    arg(ST, 32'h0000_1123, 32'h0000_4444, 32'h0);
    wr(`PCAR_REG_CTRL, {29'h0, `PCAR_CMD_INTR});
    rd(`PCAR_REG_STATUS, r);
    chk("suspended", {29'h0, r[2:0]}, 32'h0000_0004);
    wr(`PCAR_REG_CTRL, {29'h0, `PCAR_CMD_ARGUMENT_TRANSFER_INSTR});
    arg(ST | LS, 32'h0000_0456, 32'h0000_7777, 32'h5);
    chk_mem(32'h0, 32'h0000_0123);
    chk_mem(32'h1, 32'h0000_4444);
    chk_mem(32'h3, 32'h0000_1456);
    chk_mem(32'h4, 32'h0000_7777);
    chk_mem(32'h5, 32'h0000_5000);
    $display("test transfer done");
    // Padding with dummies, then surplus discarded
    call(32'h18, 32'h3);
    arg(ST | LS, 32'h0000_0321, 32'h0000_0001, 32'h0);
    // Template after the last one must be ignored
    arg(ST, 32'h0000_0555, 32'h0000_0002, 32'h0);
    wr(`PCAR_REG_CTRL, {29'h0, `PCAR_CMD_FINISH});
    settle();
    chk_mem(32'h1B, {16'h0, `PCAR_DUMMY_WORD});
    chk_mem(32'h1E, {16'h0, `PCAR_DUMMY_WORD});
    call(32'h18, 32'h0);
    arg(32'h0, 32'h0000_0ABC, 32'h0000_0DEF, 32'h0);
    rd(`PCAR_REG_TMP_BASE, r);
    chk("intermediate", r, 32'h0ABC_0DEF);
    arg(ST | LS, 32'h0000_0999, 32'h0000_0002, 32'h0);
    chk_mem(32'h18, 32'h0000_0321);
    $display("test pad and surplus done");
    // Call without arguments keeps the temporary base
    wr(`PCAR_REG_TMP_BASE, 32'h0000_5A5A);
    call(32'h30, 32'h0);
    wr(`PCAR_REG_CTRL, {29'h0, `PCAR_CMD_FINISH});
    settle();
    rd(`PCAR_REG_TMP_BASE, r);
    chk("temp base", r, 32'h0000_5A5A);
    // Dummy pointer misuse
    call(32'h30, 32'h0);
    wr(`PCAR_REG_PTR_HI, 32'h0000_0123);
    wr(`PCAR_REG_CTRL, {29'h1, `PCAR_CMD_USE_PTR});
    chk("fault real ptr", {31'h0, ptr_fault}, 32'h0);
    wr(`PCAR_REG_PTR_HI, 32'h0000_8000);
    wr(`PCAR_REG_CTRL, {29'h1, `PCAR_CMD_USE_PTR});
    chk("fault dummy", {31'h0, ptr_fault}, 32'h1);
    wr(`PCAR_REG_CTRL, {29'h0, `PCAR_CMD_FINISH});
    settle();
    $display("test fault done");
    // Return restores caller state
    wr(`PCAR_REG_SB, 32'h0000_0030);
    wr(`PCAR_REG_SAVE_SB, 32'h0000_0011);
    wr(`PCAR_REG_SAVE_LB, 32'h0000_0022);
    wr(`PCAR_REG_SAVE_KEYS, 32'h0000_ABCF);
    wr(`PCAR_REG_CUR_PC, 32'h0000_2000);
    wr(`PCAR_REG_RET_PC, 32'h0000_4100);
    wr(`PCAR_REG_CTRL, {29'h0, `PCAR_CMD_RETURN});
    settle();
    rd(`PCAR_REG_FREE_PTR, r);
    chk("free ptr", r, 32'h0000_0030);
    rd(`PCAR_REG_SB, r);
    chk("stack base", r, 32'h0000_0011);
    rd(`PCAR_REG_LB, r);
    chk("link base", r, 32'h0000_0022);
    rd(`PCAR_REG_KEYS, r);
    chk("keys", r, 32'h0000_ABCC);
    rd(`PCAR_REG_CUR_PC, r);
    chk("return pc", r, 32'h0000_6100);
    bus(1'b0, 12'h100, 32'h0, r, e);
    chk("unmapped error", {31'h0, e}, 32'h1);
    $display("test return done");
    complete_run();
  end
endmodule
